// ===== ddp_pkg.sv
// Package: register map, field positions, reset values and timing counts
package ddp_pkg;
    localparam logic [7:0] AUX_CONTROL_ONE_IDX = 8'hA2;
    localparam logic [7:0] CLOCK_CONTROL_ONE_IDX = 8'hAF;
    localparam logic [11:0] AUX_CONTROL_ONE_ADDR = 12'h288;
    localparam logic [11:0] CLOCK_CONTROL_ONE_ADDR = 12'h2BC;
    localparam logic [11:0] CPU_CLOCK_CTRL_ADDR = 12'h300;
    localparam logic [11:0] PTR_CMD_ADDR = 12'h304;
    localparam logic [11:0] PTR_ZERO_ADDR = 12'h308;
    localparam logic [11:0] PTR_ONE_ADDR = 12'h30C;
    localparam logic [11:0] PTR_ACTIVE_ADDR = 12'h310;
    localparam logic [11:0] PTR_STATUS_ADDR = 12'h314;
    localparam int POINTER_SELECT_BIT = 0;
    localparam int ZERO_BIT = 2;
    localparam int USER_FLAG_BIT = 3;
    localparam int BOOT_ROM_MAP_ENABLE_BIT = 5;
    localparam int SPI_FAST_CLOCK_SELECT_BIT = 0;
    localparam int CPU_DOUBLE_SPEED_BIT = 0;
    localparam logic [7:0] AUX_WRITE_MASK = 8'h29;
    localparam logic [7:0] AUX_RESET = 8'h00;
    localparam logic [7:0] CLOCK_CONTROL_ONE_RESET = 8'h00;
    localparam logic [15:0] BOOT_ROM_BASE = 16'hF800;
    localparam logic [3:0] OSC_PER_CYCLE_FAST = 4'h6;
    localparam logic [3:0] OSC_PER_CYCLE_STD = 4'hC;
    localparam logic [1:0] CMD_LOAD = 2'h1;
    localparam logic [1:0] CMD_INC = 2'h2;
    localparam logic [1:0] CMD_AUX_INC = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : ddp_pkg

// ===== ddp_clk_div.sv
// Clock divider: one-cycle enable every N oscillator periods
`timescale 1ns/100ps
module ddp_clk_div
    import ddp_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic [3:0] i_period,
    output logic o_tick
);
    typedef struct packed {
        logic [3:0] cnt;
        logic tick;
    } ddp_div_t;
    ddp_div_t s_q;
    ddp_div_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt >= i_period - 4'h1) begin
            s_d.cnt = 4'h0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 4'h1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_tick = s_q.tick;
endmodule : ddp_clk_div

// ===== ddp_regs.sv
// Dual data pointer, auxiliary and clock control registers on AXI4-Lite
`timescale 1ns/100ps
module ddp_regs
    import ddp_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic [11:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [11:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    input wire logic [15:0] i_code_addr,
    output logic o_boot_rom_hit,
    output logic [15:0] o_data_pointer,
    output logic o_spi_tick,
    output logic o_cpu_tick
);
    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic aw_ok;
        logic [11:0] aw_addr;
        logic w_ok;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] aux;
        logic [7:0] clk_one;
        logic cpu_double_speed;
        logic [15:0] pointer_zero;
        logic [15:0] pointer_one;
        logic boot_hit;
        logic [15:0] dp_out;
        logic aw_rdy;
        logic w_rdy;
        logic ar_rdy;
    } ddp_state_t;
    ddp_state_t s_q;
    ddp_state_t s_d;

    logic spi_tick;
    logic cpu_tick;
    logic [3:0] spi_period;
    logic [3:0] cpu_period;

    default clocking @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rstn);

    // Lane merge for a byte-strobed write
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Address decode shared by read and write paths
    function automatic logic mapped(input logic [11:0] a);
        return a == AUX_CONTROL_ONE_ADDR || a == CLOCK_CONTROL_ONE_ADDR ||
               a == CPU_CLOCK_CTRL_ADDR || a == PTR_CMD_ADDR ||
               a == PTR_ZERO_ADDR || a == PTR_ONE_ADDR ||
               a == PTR_ACTIVE_ADDR || a == PTR_STATUS_ADDR;
    endfunction : mapped

    ////////////////////////////////////////////////////////////////////////
    // Peripheral rate selection
    always_comb begin
        if (!s_q.cpu_double_speed) begin
            cpu_period = OSC_PER_CYCLE_STD;
            spi_period = OSC_PER_CYCLE_STD;
        end else begin
            cpu_period = OSC_PER_CYCLE_FAST;
            spi_period = s_q.clk_one[SPI_FAST_CLOCK_SELECT_BIT] ?
                         OSC_PER_CYCLE_STD : OSC_PER_CYCLE_FAST;
        end
    end

    ddp_clk_div u_spi_div (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_period(spi_period),
        .o_tick(spi_tick)
    );

    ddp_clk_div u_cpu_div (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_period(cpu_period),
        .o_tick(cpu_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [31:0] wv;
        logic [31:0] cur;
        logic sel;
        wv = '0;
        cur = '0;
        s_d = s_q;
        sel = s_q.aux[POINTER_SELECT_BIT];
        if (i_awvalid && s_q.aw_rdy) begin
            s_d.aw_ok = 1'b1;
            s_d.aw_addr = i_awaddr;
        end
        if (i_wvalid && s_q.w_rdy) begin
            s_d.w_ok = 1'b1;
            s_d.w_data = i_wdata;
            s_d.w_strb = i_wstrb;
        end
        if (s_q.bvalid && i_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.aw_ok && s_q.w_ok && !s_q.bvalid) begin
            s_d.aw_ok = 1'b0;
            s_d.w_ok = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = mapped(s_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_q.aw_addr)
                AUX_CONTROL_ONE_ADDR: begin
                    wv = merge({24'h0, s_q.aux}, s_q.w_data, s_q.w_strb);
                    s_d.aux = wv[7:0] & AUX_WRITE_MASK;
                end
                CLOCK_CONTROL_ONE_ADDR: begin
                    wv = merge({24'h0, s_q.clk_one}, s_q.w_data, s_q.w_strb);
                    s_d.clk_one = {7'h0, wv[SPI_FAST_CLOCK_SELECT_BIT]};
                end
                CPU_CLOCK_CTRL_ADDR: begin
                    if (s_q.w_strb[0]) begin
                        s_d.cpu_double_speed =
                            s_q.w_data[CPU_DOUBLE_SPEED_BIT];
                    end
                end
                PTR_CMD_ADDR: begin
                    if (s_q.w_strb[0]) begin
                        unique case (s_q.w_data[1:0])
                            CMD_LOAD: begin
                                // Only the active pointer is touched
                                if (sel) begin
                                    s_d.pointer_one = s_q.w_data[31:16];
                                end else begin
                                    s_d.pointer_zero = s_q.w_data[31:16];
                                end
                            end
                            CMD_INC: begin
                                if (sel) begin
                                    s_d.pointer_one = s_q.pointer_one + 16'h1;
                                end else begin
                                    s_d.pointer_zero =
                                        s_q.pointer_zero + 16'h1;
                                end
                            end
                            CMD_AUX_INC: begin
                                // Carry out of bit 0 dies in bit 1, which the write mask clears
                                wv = {24'h0, s_q.aux} + 32'h1;
                                s_d.aux = wv[7:0] & AUX_WRITE_MASK;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                PTR_ZERO_ADDR: begin
                    wv = merge({16'h0, s_q.pointer_zero}, s_q.w_data,
                               s_q.w_strb);
                    s_d.pointer_zero = wv[15:0];
                end
                PTR_ONE_ADDR: begin
                    wv = merge({16'h0, s_q.pointer_one}, s_q.w_data,
                               s_q.w_strb);
                    s_d.pointer_one = wv[15:0];
                end
                default: begin
                end
            endcase
        end
        if (s_q.rvalid && i_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (i_arvalid && s_q.ar_rdy) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (i_araddr)
                AUX_CONTROL_ONE_ADDR: cur = {24'h0, s_q.aux};
                CLOCK_CONTROL_ONE_ADDR: cur = {24'h0, s_q.clk_one};
                CPU_CLOCK_CTRL_ADDR: cur = {31'h0, s_q.cpu_double_speed};
                PTR_ZERO_ADDR: cur = {16'h0, s_q.pointer_zero};
                PTR_ONE_ADDR: cur = {16'h0, s_q.pointer_one};
                PTR_ACTIVE_ADDR: cur = {16'h0, s_q.dp_out};
                PTR_STATUS_ADDR: cur = {30'h0, s_q.boot_hit, sel};
                default: cur = '0;
            endcase
            s_d.rdata = cur;
        end
        s_d.dp_out = s_d.aux[POINTER_SELECT_BIT] ?
                     s_d.pointer_one : s_d.pointer_zero;
        s_d.boot_hit = s_d.aux[BOOT_ROM_MAP_ENABLE_BIT] &&
                       (i_code_addr >= BOOT_ROM_BASE);
        // Readies are registered, so they stay low through reset
        s_d.aw_rdy = !s_d.aw_ok;
        s_d.w_rdy = !s_d.w_ok;
        s_d.ar_rdy = !s_d.rvalid;
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            s_q <= '0;
            s_q.aux <= AUX_RESET;
            s_q.clk_one <= CLOCK_CONTROL_ONE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    logic spi_q;
    logic cpu_q;
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn) begin
            spi_q <= 1'b0;
            cpu_q <= 1'b0;
        end else begin
            spi_q <= spi_tick;
            cpu_q <= cpu_tick;
        end
    end

    assign o_awready = s_q.aw_rdy;
    assign o_wready = s_q.w_rdy;
    assign o_bvalid = s_q.bvalid;
    assign o_bresp = s_q.bresp;
    assign o_arready = s_q.ar_rdy;
    assign o_rvalid = s_q.rvalid;
    assign o_rdata = s_q.rdata;
    assign o_rresp = s_q.rresp;
    assign o_boot_rom_hit = s_q.boot_hit;
    assign o_data_pointer = s_q.dp_out;
    assign o_spi_tick = spi_q;
    assign o_cpu_tick = cpu_q;

    ////////////////////////////////////////////////////////////////////////
    // Helper: cycles since last SPI tick
    logic [4:0] spi_gap_q;
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn || spi_tick) begin
            spi_gap_q <= 5'h0;
        end else if (spi_gap_q != 5'h1F) begin
            spi_gap_q <= spi_gap_q + 5'h1;
        end
    end

    // Helper: cycles since last CPU tick
    logic [4:0] cpu_gap_q;
    always_ff @(posedge i_sys_clk) begin
        if (!i_rstn || cpu_tick) begin
            cpu_gap_q <= 5'h0;
        end else if (cpu_gap_q != 5'h1F) begin
            cpu_gap_q <= cpu_gap_q + 5'h1;
        end
    end

    a_spi_slow_std: assert property (
        spi_tick && !s_q.cpu_double_speed && $past(spi_tick, 12) &&
        $stable(s_q.cpu_double_speed) |-> spi_gap_q == 5'hB)
        else $error("SPI rate wrong in standard mode");
    a_spi_fast_rate: assert property (
        spi_tick && s_q.cpu_double_speed &&
        !s_q.clk_one[SPI_FAST_CLOCK_SELECT_BIT] |-> spi_gap_q >= 5'h5)
        else $error("SPI tick too early in fast mode");
    a_cpu_std_rate: assert property (
        !s_q.cpu_double_speed ##1 cpu_tick |-> cpu_gap_q >= 5'hB)
        else $error("CPU tick too early in standard mode");
    a_clk_reset: assert property (
        $rose(i_rstn) |-> s_q.clk_one == 8'h00 && s_q.aux == 8'h00)
        else $error("Registers not cleared by reset");
    a_aux_zero_bit: assert property (
        !s_q.aux[ZERO_BIT] && !s_q.aux[4] && !s_q.aux[1])
        else $error("Hard zero bit set");
    a_aux_inc_toggle: assert property (
        s_q.aw_ok && s_q.w_ok && !s_q.bvalid && s_q.aw_addr == PTR_CMD_ADDR &&
        s_q.w_strb[0] && s_q.w_data[1:0] == CMD_AUX_INC
        |=> s_q.aux[POINTER_SELECT_BIT] != $past(s_q.aux[POINTER_SELECT_BIT])
            && $stable(s_q.aux[USER_FLAG_BIT]))
        else $error("Increment did not toggle select only");
    a_pointer_route: assert property (
        ##1 o_data_pointer == (s_q.aux[POINTER_SELECT_BIT] ?
                               s_q.pointer_one : s_q.pointer_zero))
        else $error("Active pointer misrouted");
    a_idle_pointer: assert property (
        !s_q.aux[POINTER_SELECT_BIT] && s_q.aw_addr != PTR_ONE_ADDR
        |=> $stable(s_q.pointer_one))
        else $error("Unselected pointer changed");
    a_idle_pointer_zero: assert property (
        s_q.aux[POINTER_SELECT_BIT] && s_q.aw_addr != PTR_ZERO_ADDR
        |=> $stable(s_q.pointer_zero))
        else $error("Unselected pointer zero changed");
    a_boot_map: assert property (
        o_boot_rom_hit |-> $past(i_code_addr) >= BOOT_ROM_BASE)
        else $error("Boot ROM hit below base");
    a_boot_enable: assert property (
        o_boot_rom_hit |-> s_q.aux[BOOT_ROM_MAP_ENABLE_BIT])
        else $error("Boot ROM hit while disabled");

    c_aux_inc: cover property ($changed(s_q.aux[POINTER_SELECT_BIT]));
    c_fast_spi: cover property (spi_tick && s_q.cpu_double_speed);
    c_boot: cover property (o_boot_rom_hit);
    c_slverr: cover property (o_bvalid && o_bresp == RESP_SLVERR);
endmodule : ddp_regs

// ===== dual_data_pointer_aux_regs_bench.sv
// Testbench: register bus, data pointers, boot mapping and clock ticks
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    n_mismatch++; $display("mismatch %s expected %0h seen %0h", nm, e, g); \
    end end
module dual_data_pointer_aux_regs_bench;
    import ddp_pkg::*;
    localparam int LIMIT = 20000;
    logic clk, rstn, awvalid, wvalid, bready, arvalid, rready;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, wresp, rs;
    logic awready, wready, bvalid, arready, rvalid;
    logic [15:0] code_addr, data_pointer;
    logic boot_hit, spi_tick, cpu_tick;
    int n_mismatch, n_compared, cycles, p;
    int tbl [4][4] = '{'{0, 0, 12, 12}, '{0, 1, 12, 12},
                       '{1, 1, 12, 6}, '{1, 0, 6, 6}};

    ddp_regs dut (.i_sys_clk(clk), .i_rstn(rstn), .i_awaddr(awaddr),
        .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
        .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
        .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
        .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
        .i_rready(rready), .i_code_addr(code_addr),
        .o_boot_rom_hit(boot_hit), .o_data_pointer(data_pointer),
        .o_spi_tick(spi_tick), .o_cpu_tick(cpu_tick));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_mismatch++;
            complete_run();
        end
    end

    // Write address and data offered together, each dropped when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        wresp = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rdr(input logic [11:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : rdr

    task automatic chk_reg(input logic [11:0] a, input logic [31:0] e,
                           input string nm);
        rdr(a);
        `CHK(nm, e, rd)
        `CHK("read response", RESP_OKAY, rs)
    endtask : chk_reg

    // Edges between two sampled pulses; the first gap is discarded
    task automatic period(input bit spi, output int n);
        repeat (2) begin
            n = 0;
            do @(posedge clk); while (!(spi ? spi_tick : cpu_tick));
            do begin
                @(posedge clk);
                n++;
            end while (!(spi ? spi_tick : cpu_tick));
        end
    endtask : period

    task automatic chk_ptr(input logic [15:0] e);
        repeat (2) @(posedge clk);
        `CHK("active pointer", e, data_pointer)
    endtask : chk_ptr

    task automatic chk_hit(input logic [15:0] a, input logic e);
        @(posedge clk);
        code_addr <= a;
        repeat (3) @(posedge clk);
        `CHK("boot hit", e, boot_hit)
    endtask : chk_hit

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = '0;
        code_addr = '0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        chk_reg(AUX_CONTROL_ONE_ADDR, 32'h0, "aux reset");
        chk_reg(CLOCK_CONTROL_ONE_ADDR, 32'h0, "clk1 reset");
        chk_ptr(16'h0000);
        // Every pairing of double speed and fast SPI select
        for (int i = 0; i < 4; i++) begin
            wr(CPU_CLOCK_CTRL_ADDR, 32'(tbl[i][0]), 4'hF);
            wr(CLOCK_CONTROL_ONE_ADDR, 32'(tbl[i][1]), 4'hF);
            period(1'b1, p);
            `CHK("spi period", tbl[i][2], p)
            period(1'b0, p);
            `CHK("cpu period", tbl[i][3], p)
        end
        chk_reg(CLOCK_CONTROL_ONE_ADDR, 32'h0, "clk1 readback");
        chk_reg(CPU_CLOCK_CTRL_ADDR, 32'h1, "double speed");
        wr(AUX_CONTROL_ONE_ADDR, 32'h0000_002D, 4'hF);
        chk_reg(AUX_CONTROL_ONE_ADDR, 32'h29, "aux zero bit");
        chk_hit(16'hF7FF, 1'b0);
        chk_hit(16'hF800, 1'b1);
        chk_hit(16'hFFFF, 1'b1);
        chk_reg(PTR_STATUS_ADDR, 32'h3, "status");
        wr(PTR_CMD_ADDR, {30'h0, CMD_AUX_INC}, 4'hF);
        chk_reg(AUX_CONTROL_ONE_ADDR, 32'h28, "aux inc once");
        wr(PTR_CMD_ADDR, {30'h0, CMD_AUX_INC}, 4'hF);
        chk_reg(AUX_CONTROL_ONE_ADDR, 32'h29, "aux inc twice");
        wr(AUX_CONTROL_ONE_ADDR, 32'h0000_0008, 4'hF);
        chk_hit(16'hFFFF, 1'b0);
        wr(PTR_CMD_ADDR, {16'h1234, 14'h0, CMD_LOAD}, 4'hF);
        chk_ptr(16'h1234);
        chk_reg(PTR_ZERO_ADDR, 32'h1234, "pointer zero");
        chk_reg(PTR_ONE_ADDR, 32'h0, "pointer one idle");
        wr(PTR_CMD_ADDR, {30'h0, CMD_AUX_INC}, 4'hF);
        chk_reg(AUX_CONTROL_ONE_ADDR, 32'h09, "aux flag kept");
        wr(PTR_CMD_ADDR, {16'hFFFF, 14'h0, CMD_LOAD}, 4'hF);
        chk_ptr(16'hFFFF);
        wr(PTR_CMD_ADDR, {30'h0, CMD_INC}, 4'hF);
        chk_reg(PTR_ACTIVE_ADDR, 32'h0, "pointer wrap");
        chk_reg(PTR_ZERO_ADDR, 32'h1234, "pointer zero kept");
        wr(PTR_CMD_ADDR, {30'h0, CMD_AUX_INC}, 4'hF);
        chk_ptr(16'h1234);
        // Strobe without the low byte leaves the register alone
        wr(AUX_CONTROL_ONE_ADDR, 32'h0000_0000, 4'hE);
        chk_reg(AUX_CONTROL_ONE_ADDR, 32'h08, "aux strobe");
        rdr(12'h400);
        `CHK("unmapped read resp", RESP_SLVERR, rs)
        `CHK("unmapped read data", 32'h0, rd)
        wr(12'h400, 32'h0000_0001, 4'hF);
        `CHK("unmapped write resp", RESP_SLVERR, wresp)
        complete_run();
    end
endmodule : dual_data_pointer_aux_regs_bench
